// *** rtl/pols_supervisor.sv ***
// output supervisor: setpoint limits, faults, regulation flag, sync, rail
// Behaviour
// - enabled setpoint capped by enable-time bin
// - disabled: only strap maximum limits setpoint
// - setpoint clamped to 110% strap nominal
// - over-voltage flagged above limit, default 115%
// - over-voltage: shutdown with retries or crowbar
// - default crowbar, recheck, re-enable when gone
// - external sync forces shutdown response
// - under-voltage flagged below limit, default 85%
// - regulation flag only in tolerance, no fault
// - regulation pin open-drain default, push-pull option
// - assert above 90%, release below 85%
// - programmable assertion delay, default 10 ms
// - with tuning, assert when tuning completes
// - frequency 320 kHz default, 200 to 640
// - internal clock default; one sync master
// - sixteen configurable phase positions
// - at most seven rail members
// - members active until regulation; drop afterwards
// - lowest active member becomes reference
// - phase recomputed on active count change
// - shut-down rail members restart together; crowbar does not wait
// - five selectable over-current responses
// - default over-current: shut down, re-enable
`timescale 1ns/10ps
`default_nettype none
module pols_supervisor #(
	parameter int unsigned CYC_MS = pols_pkg::CYC_PER_MS
) (
	input wire logic clk,
	input wire logic nrst,
	input wire logic [7:0] addr,
	input wire logic [15:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [15:0] rdata,
	input wire logic output_enable,
	input wire logic [12:0] setpoint_resistor,
	input wire logic [12:0] vout_mv,
	input wire logic oc_detect,
	input wire logic tuning_done,
	input wire logic sw_clk_int,
	output logic sw_clk,
	output logic high_side_en,
	output logic low_side_en,
	output logic output_in_regulation_o,
	output logic output_in_regulation_oe_n,
	input wire logic sync_i,
	output logic sync_o,
	output logic sync_oe_n,
	output logic [9:0] freq_khz,
	output logic [3:0] phase_pos,
	output logic is_reference,
	input wire logic [6:0] gbus_active_in,
	output logic gbus_active_out,
	input wire logic gbus_fault_in,
	output logic gbus_fault_out
);
	localparam logic [15:0] MS_LAST = 16'(CYC_MS - 1);

	typedef struct packed {
		logic [15:0] ms_cnt;
		pols_pkg::pols_st_t st;
		logic strap_done;
		logic [12:0] vnom;
		logic [12:0] vset;
		logic [12:0] cap;
		logic [6:0] ctrl;
		logic [7:0] ov_pct;
		logic [7:0] uv_pct;
		logic [7:0] pgon_pct;
		logic [7:0] pgoff_pct;
		logic [7:0] fcfg;
		logic [7:0] pg_dly;
		logic [7:0] rs_dly;
		logic [7:0] oc_dly;
		logic [9:0] freq;
		logic [3:0] phase_cfg;
		logic [2:0] member;
		logic lim;
		logic dly_en;
		logic [3:0] retry;
		logic [7:0] dly_cnt;
		logic pg;
		logic [7:0] pg_cnt;
		logic pg_seen;
		logic dropped;
		logic [2:0] act_cnt;
		logic [3:0] phase;
		logic [15:0] rdata;
	} pols_sup_t;

	pols_sup_t s_q;
	pols_sup_t s_d;
	logic [14:0] ov_thr;
	logic [14:0] uv_thr;
	logic [14:0] pgon_thr;
	logic [14:0] pgoff_thr;
	logic [14:0] vmax_thr;
	logic ms_tick;
	logic ext_sync;
	logic ov;
	logic uv;
	logic oc;
	logic in_band;
	logic pg_cond;
	logic self_act;
	logic [6:0] act_mask;
	logic [2:0] order;
	logic [2:0] cnt;
	logic ref_hit;
	logic [14:0] lim_v;
	logic [14:0] wv;
	logic [15:0] status;

	function automatic logic [12:0] bin_cap(input logic [12:0] v);
		logic [12:0] c;
		c = pols_pkg::BIN_CAP[5];
		for (int i = 4; i >= 0; i--) begin
			if (v <= pols_pkg::BIN_EDGE[i]) begin
				c = pols_pkg::BIN_CAP[i];
			end
		end
		return c;
	endfunction

	function automatic logic [2:0] pop_below(input logic [6:0] m,
		input logic [2:0] lim);
		logic [2:0] n;
		n = 3'h0;
		for (int i = 0; i < 7; i++) begin
			if (m[i] && (3'(i) < lim)) begin
				n = n + 3'h1;
			end
		end
		return n;
	endfunction

	// thresholds track the active setpoint; the ceiling tracks the strap
	pols_scale u_ov (.clk(clk), .nrst(nrst), .nom(s_q.vset),
		.pct(s_q.ov_pct), .thr(ov_thr));
	pols_scale u_uv (.clk(clk), .nrst(nrst), .nom(s_q.vset),
		.pct(s_q.uv_pct), .thr(uv_thr));
	pols_scale u_pgon (.clk(clk), .nrst(nrst), .nom(s_q.vset),
		.pct(s_q.pgon_pct), .thr(pgon_thr));
	pols_scale u_pgoff (.clk(clk), .nrst(nrst), .nom(s_q.vset),
		.pct(s_q.pgoff_pct), .thr(pgoff_thr));
	pols_scale u_vmax (.clk(clk), .nrst(nrst), .nom(s_q.vnom),
		.pct(pols_pkg::VMAX_PCT), .thr(vmax_thr));

	always_comb begin
		ms_tick = (s_q.ms_cnt == MS_LAST);
		ext_sync = (s_q.ctrl[5:4] == pols_pkg::SYNC_IN);
		ov = ({2'h0, vout_mv} > ov_thr);
		uv = (s_q.st == pols_pkg::ST_RUN) && ({2'h0, vout_mv} < uv_thr);
		oc = oc_detect;
		in_band = s_q.pg ? ({2'h0, vout_mv} >= pgoff_thr)
			: ({2'h0, vout_mv} > pgon_thr);
		pg_cond = in_band && (s_q.st == pols_pkg::ST_RUN) && !ov && !uv
			&& !oc && !s_q.dropped;
		self_act = s_q.ctrl[pols_pkg::C_RAIL_EN] && !s_q.dropped;
		act_mask = gbus_active_in | (7'(self_act) << s_q.member);
		order = pop_below(act_mask, s_q.member);
		cnt = pop_below(act_mask, 3'h7);
		ref_hit = self_act && (order == 3'h0);
		lim_v = vmax_thr;
		if ((s_q.st != pols_pkg::ST_OFF) && ({2'h0, s_q.cap} < lim_v)) begin
			lim_v = {2'h0, s_q.cap};
		end
		wv = {2'h0, wdata[12:0]};
		status = {3'h0, s_q.st, s_q.phase, ref_hit, s_q.dropped, oc, uv,
			ov, s_q.pg};

		s_d = s_q;
		s_d.rdata = 16'h0000;
		s_d.ms_cnt = ms_tick ? 16'h0000 : s_q.ms_cnt + 16'h0001;
		if (!s_q.strap_done) begin
			s_d.strap_done = 1'b1;
			s_d.vnom = setpoint_resistor;
			s_d.vset = setpoint_resistor;
		end

		if (wr) begin
			unique case (addr)
				pols_pkg::A_CTRL: s_d.ctrl = wdata[6:0];
				pols_pkg::A_VSET: s_d.vset = (wv > lim_v) ? lim_v[12:0] : wdata[12:0];
				pols_pkg::A_OV_PCT: s_d.ov_pct = wdata[7:0];
				pols_pkg::A_UV_PCT: s_d.uv_pct = wdata[7:0];
				pols_pkg::A_PGON_PCT: s_d.pgon_pct = wdata[7:0];
				pols_pkg::A_PGOFF_PCT: s_d.pgoff_pct = wdata[7:0];
				pols_pkg::A_FAULT_CFG: s_d.fcfg = wdata[7:0];
				pols_pkg::A_PG_DLY: s_d.pg_dly = wdata[7:0];
				pols_pkg::A_RS_DLY: s_d.rs_dly = wdata[7:0];
				pols_pkg::A_OC_DLY: s_d.oc_dly = wdata[7:0];
				pols_pkg::A_FREQ: begin
					if ((wdata[15:10] == 6'h00) && (wdata[9:0] >= pols_pkg::FREQ_MIN)
						&& (wdata[9:0] <= pols_pkg::FREQ_MAX)) begin
						s_d.freq = wdata[9:0];
					end
				end
				pols_pkg::A_PHASE: s_d.phase_cfg = wdata[3:0];
				pols_pkg::A_MEMBER: begin
					if (wdata[2:0] <= pols_pkg::MEMBER_MAX) begin
						s_d.member = wdata[2:0];
					end
				end
				default: begin
				end
			endcase
		end
		if (rd) begin
			unique case (addr)
				pols_pkg::A_CTRL: s_d.rdata = {9'h000, s_q.ctrl};
				pols_pkg::A_VSET: s_d.rdata = {3'h0, s_q.vset};
				pols_pkg::A_OV_PCT: s_d.rdata = {8'h00, s_q.ov_pct};
				pols_pkg::A_UV_PCT: s_d.rdata = {8'h00, s_q.uv_pct};
				pols_pkg::A_PGON_PCT: s_d.rdata = {8'h00, s_q.pgon_pct};
				pols_pkg::A_PGOFF_PCT: s_d.rdata = {8'h00, s_q.pgoff_pct};
				pols_pkg::A_FAULT_CFG: s_d.rdata = {8'h00, s_q.fcfg};
				pols_pkg::A_PG_DLY: s_d.rdata = {8'h00, s_q.pg_dly};
				pols_pkg::A_RS_DLY: s_d.rdata = {8'h00, s_q.rs_dly};
				pols_pkg::A_OC_DLY: s_d.rdata = {8'h00, s_q.oc_dly};
				pols_pkg::A_FREQ: s_d.rdata = {6'h00, s_q.freq};
				pols_pkg::A_PHASE: s_d.rdata = {12'h000, s_q.phase_cfg};
				pols_pkg::A_MEMBER: s_d.rdata = {13'h0000, s_q.member};
				pols_pkg::A_STATUS: s_d.rdata = status;
				pols_pkg::A_VMAX: s_d.rdata = {1'h0, vmax_thr};
				default: s_d.rdata = 16'h0000;
			endcase
		end

		// output state machine
		unique case (s_q.st)
			pols_pkg::ST_OFF: begin
				s_d.retry = 4'h0;
				if (output_enable && s_q.strap_done) begin
					s_d.st = pols_pkg::ST_RUN;
					s_d.cap = bin_cap(s_q.vset);
				end
			end
			pols_pkg::ST_RUN: begin
				if (ov) begin
					if (!s_q.fcfg[0] && !ext_sync) begin
						s_d.st = pols_pkg::ST_CROW;
					end else begin
						s_d.st = pols_pkg::ST_SHUT;
						s_d.lim = 1'b1;
						s_d.dly_en = 1'b0;
					end
				end else if (oc) begin
					unique case (s_q.fcfg[3:1])
						pols_pkg::OC_ENDLESS, pols_pkg::OC_COUNT: begin
							s_d.st = pols_pkg::ST_SHUT;
							s_d.lim = (s_q.fcfg[3:1] == pols_pkg::OC_COUNT);
							s_d.dly_en = 1'b1;
						end
						pols_pkg::OC_DELAYED: begin
							if (s_q.dly_cnt >= s_q.oc_dly) begin
								s_d.st = pols_pkg::ST_LATCH;
							end else if (ms_tick) begin
								s_d.dly_cnt = s_q.dly_cnt + 8'h01;
							end
						end
						pols_pkg::OC_RIDE: begin
						end
						default: begin
							s_d.st = pols_pkg::ST_SHUT;
							s_d.lim = 1'b0;
							s_d.dly_en = 1'b0;
						end
					endcase
				end else begin
					s_d.dly_cnt = 8'h00;
				end
			end
			pols_pkg::ST_SHUT: begin
				s_d.dly_cnt = 8'h00;
				if (!ov && !oc) begin
					if (s_q.lim && (s_q.retry >= s_q.fcfg[7:4])) begin
						s_d.st = pols_pkg::ST_LATCH;
					end else begin
						s_d.st = pols_pkg::ST_RWAIT;
						if (s_q.retry != 4'hf) begin
							s_d.retry = s_q.retry + 4'h1;
						end
					end
				end
			end
			pols_pkg::ST_RWAIT: begin
				if (!s_q.dly_en || (s_q.dly_cnt >= s_q.rs_dly)) begin
					if (!s_q.ctrl[pols_pkg::C_RAIL_EN] || !gbus_fault_in) begin
						s_d.st = pols_pkg::ST_RUN;
						s_d.dly_cnt = 8'h00;
					end
				end else if (ms_tick) begin
					s_d.dly_cnt = s_q.dly_cnt + 8'h01;
				end
			end
			pols_pkg::ST_CROW: begin
				if (!ov) begin
					s_d.st = pols_pkg::ST_RUN;
				end
			end
			pols_pkg::ST_LATCH: begin
			end
			default: s_d.st = pols_pkg::ST_OFF;
		endcase
		if (!output_enable) begin
			s_d.st = pols_pkg::ST_OFF;
			s_d.dly_cnt = 8'h00;
		end

		// regulation flag with delay or tuning handshake
		if (!pg_cond) begin
			s_d.pg = 1'b0;
			s_d.pg_cnt = 8'h00;
		end else if (!s_q.pg) begin
			if (s_q.ctrl[pols_pkg::C_TUNE_EN]
				&& s_q.ctrl[pols_pkg::C_PG_AFTER_TUNE]) begin
				s_d.pg = tuning_done;
			end else if (s_q.pg_cnt >= s_q.pg_dly) begin
				s_d.pg = 1'b1;
			end else if (ms_tick) begin
				s_d.pg_cnt = s_q.pg_cnt + 8'h01;
			end
		end

		// rail membership and phase order
		if (s_q.st == pols_pkg::ST_OFF) begin
			s_d.pg_seen = 1'b0;
			s_d.dropped = 1'b0;
		end else begin
			if (s_q.pg) begin
				s_d.pg_seen = 1'b1;
			end
			s_d.dropped = s_q.ctrl[pols_pkg::C_DROP] && s_q.pg_seen
				&& s_q.ctrl[pols_pkg::C_RAIL_EN];
		end
		s_d.act_cnt = cnt;
		if (!s_q.ctrl[pols_pkg::C_RAIL_EN]) begin
			s_d.phase = s_q.phase_cfg;
		end else if (cnt != s_q.act_cnt) begin
			s_d.phase = {1'b0, order};
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			s_q <= '0;
			s_q.st <= pols_pkg::ST_OFF;
			s_q.ctrl <= pols_pkg::CTRL_RST;
			s_q.ov_pct <= pols_pkg::OV_PCT_RST;
			s_q.uv_pct <= pols_pkg::UV_PCT_RST;
			s_q.pgon_pct <= pols_pkg::PGON_PCT_RST;
			s_q.pgoff_pct <= pols_pkg::PGOFF_PCT_RST;
			s_q.fcfg <= pols_pkg::FCFG_RST;
			s_q.pg_dly <= pols_pkg::PG_DLY_RST;
			s_q.rs_dly <= pols_pkg::RS_DLY_RST;
			s_q.oc_dly <= pols_pkg::OC_DLY_RST;
			s_q.freq <= pols_pkg::FREQ_RST;
		end else begin
			s_q <= s_d;
		end
	end

	assign rdata = s_q.rdata;
	assign high_side_en = (s_q.st == pols_pkg::ST_RUN) && !s_q.dropped;
	assign low_side_en = (s_q.st == pols_pkg::ST_CROW);
	assign output_in_regulation_o = s_q.ctrl[pols_pkg::C_PG_PUSHPULL]
		&& s_q.pg;
	assign output_in_regulation_oe_n = !s_q.ctrl[pols_pkg::C_PG_PUSHPULL]
		&& s_q.pg;
	// sync_o reaches the shared pin only while sync mode selects output
	assign sw_clk = ext_sync ? sync_i : sw_clk_int;
	assign sync_o = sw_clk_int;
	assign sync_oe_n = (s_q.ctrl[5:4] != pols_pkg::SYNC_OUT);
	assign freq_khz = s_q.freq;
	assign phase_pos = s_q.phase;
	assign is_reference = ref_hit;
	assign gbus_active_out = self_act;
	assign gbus_fault_out = (s_q.st == pols_pkg::ST_SHUT)
		|| (s_q.st == pols_pkg::ST_CROW);

	AST_CAP_EN: assert property (@(posedge clk) disable iff (!nrst)
		(wr && addr == pols_pkg::A_VSET && s_q.st == pols_pkg::ST_RUN
		&& $stable(s_q.cap)) |=> (s_q.vset <= s_q.cap))
		else $error("setpoint above enabled cap");
	AST_OFF_FREE: assert property (@(posedge clk) disable iff (!nrst)
		(wr && addr == pols_pkg::A_VSET && s_q.st == pols_pkg::ST_OFF
		&& wdata[15:13] == 3'h0 && {2'h0, wdata[12:0]} <= vmax_thr)
		|=> (s_q.vset == $past(wdata[12:0])))
		else $error("disabled setpoint write not taken");
	AST_VMAX: assert property (@(posedge clk) disable iff (!nrst)
		(wr && addr == pols_pkg::A_VSET && $stable(vmax_thr))
		|=> ({2'h0, s_q.vset} <= vmax_thr))
		else $error("setpoint above strap maximum");
	AST_CROW: assert property (@(posedge clk) disable iff (!nrst)
		(s_q.st == pols_pkg::ST_CROW) |-> (low_side_en && !high_side_en))
		else $error("crowbar switch state wrong");
	AST_EXT_SYNC: assert property (@(posedge clk) disable iff (!nrst)
		(s_q.st == pols_pkg::ST_RUN && ov && ext_sync && output_enable)
		|=> (s_q.st == pols_pkg::ST_SHUT))
		else $error("external sync over-voltage not shut down");
	AST_PG_FAULT: assert property (@(posedge clk) disable iff (!nrst)
		s_q.pg |-> ($past(s_q.st) == pols_pkg::ST_RUN && !$past(ov)))
		else $error("regulation flag during fault");
	AST_PG_OD: assert property (@(posedge clk) disable iff (!nrst)
		!s_q.ctrl[pols_pkg::C_PG_PUSHPULL]
		|-> (!output_in_regulation_o && output_in_regulation_oe_n == s_q.pg))
		else $error("open-drain regulation pin misdriven");
	AST_PG_DLY: assert property (@(posedge clk) disable iff (!nrst)
		($rose(s_q.pg) && !$past(s_q.ctrl[pols_pkg::C_TUNE_EN]))
		|-> ($past(s_q.pg_cnt) >= $past(s_q.pg_dly)))
		else $error("regulation flag before delay");
	AST_FREQ: assert property (@(posedge clk) disable iff (!nrst)
		1'b1 |-> (s_q.freq >= pols_pkg::FREQ_MIN
		&& s_q.freq <= pols_pkg::FREQ_MAX))
		else $error("frequency outside range");
	AST_MEMBER: assert property (@(posedge clk) disable iff (!nrst)
		(wr && addr == pols_pkg::A_MEMBER && wdata[2:0] == 3'h7)
		|=> $stable(s_q.member))
		else $error("eighth member position accepted");
	AST_DROP: assert property (@(posedge clk) disable iff (!nrst)
		$rose(s_q.dropped) |-> $past(s_q.pg_seen))
		else $error("member dropped before regulation");
endmodule
`default_nettype wire

// *** rtl/pols_pkg.sv ***
// constants, offsets and types of the point-of-load supervisor
package pols_pkg;
	localparam int unsigned CLK_NS = 20;
	localparam int unsigned MS_NS = 1000000;
	localparam int unsigned CYC_PER_MS = MS_NS / CLK_NS;

	localparam logic [7:0] A_CTRL = 8'h00;
	localparam logic [7:0] A_VSET = 8'h01;
	localparam logic [7:0] A_OV_PCT = 8'h02;
	localparam logic [7:0] A_UV_PCT = 8'h03;
	localparam logic [7:0] A_PGON_PCT = 8'h04;
	localparam logic [7:0] A_PGOFF_PCT = 8'h05;
	localparam logic [7:0] A_FAULT_CFG = 8'h06;
	localparam logic [7:0] A_PG_DLY = 8'h07;
	localparam logic [7:0] A_RS_DLY = 8'h08;
	localparam logic [7:0] A_OC_DLY = 8'h09;
	localparam logic [7:0] A_FREQ = 8'h0a;
	localparam logic [7:0] A_PHASE = 8'h0b;
	localparam logic [7:0] A_MEMBER = 8'h0c;
	localparam logic [7:0] A_STATUS = 8'h0d;
	localparam logic [7:0] A_VMAX = 8'h0e;

	localparam int unsigned C_RAIL_EN = 0;
	localparam int unsigned C_TUNE_EN = 1;
	localparam int unsigned C_PG_PUSHPULL = 2;
	localparam int unsigned C_PG_AFTER_TUNE = 3;
	localparam int unsigned C_SYNC_LO = 4;
	localparam int unsigned C_DROP = 6;
	localparam logic [6:0] CTRL_RST = 7'h08;

	localparam logic [1:0] SYNC_INT = 2'h0;
	localparam logic [1:0] SYNC_IN = 2'h1;
	localparam logic [1:0] SYNC_OUT = 2'h2;

	localparam logic [2:0] OC_IMM = 3'h0;
	localparam logic [2:0] OC_ENDLESS = 3'h1;
	localparam logic [2:0] OC_COUNT = 3'h2;
	localparam logic [2:0] OC_DELAYED = 3'h3;
	localparam logic [2:0] OC_RIDE = 3'h4;
	localparam logic [7:0] FCFG_RST = 8'h00;

	localparam logic [7:0] OV_PCT_RST = 8'h73;
	localparam logic [7:0] UV_PCT_RST = 8'h55;
	localparam logic [7:0] PGON_PCT_RST = 8'h5a;
	localparam logic [7:0] PGOFF_PCT_RST = 8'h55;
	localparam logic [7:0] VMAX_PCT = 8'h6e;
	localparam logic [7:0] PG_DLY_RST = 8'h0a;
	localparam logic [7:0] RS_DLY_RST = 8'h0a;
	localparam logic [7:0] OC_DLY_RST = 8'h0a;

	localparam logic [9:0] FREQ_RST = 10'h140;
	localparam logic [9:0] FREQ_MIN = 10'h0c8;
	localparam logic [9:0] FREQ_MAX = 10'h280;
	localparam logic [2:0] MEMBER_MAX = 3'h6;

	// upper edges of the setpoint bins and the cap allowed per bin, in mV
	localparam logic [12:0] BIN_EDGE [0:4] = '{13'h3dc, 13'h567, 13'h7b7,
		13'h95e, 13'hb93};
	localparam logic [12:0] BIN_CAP [0:5] = '{13'h4b0, 13'h6a4, 13'h9c4,
		13'hb9a, 13'he60, 13'h122a};

	typedef enum logic [2:0] {
		ST_OFF = 3'h0,
		ST_RUN = 3'h1,
		ST_SHUT = 3'h3,
		ST_RWAIT = 3'h2,
		ST_CROW = 3'h5,
		ST_LATCH = 3'h7
	} pols_st_t;
endpackage

// *** rtl/pols_scale.sv ***
// registered percentage of a nominal voltage
`timescale 1ns/10ps
`default_nettype none
module pols_scale (
	input wire logic clk,
	input wire logic nrst,
	input wire logic [12:0] nom,
	input wire logic [7:0] pct,
	output logic [14:0] thr
);
	typedef struct packed {
		logic [14:0] thr;
	} pols_scale_t;

	pols_scale_t s_q;
	pols_scale_t s_d;
	logic [20:0] prod;
	logic [20:0] quo;

	always_comb begin
		prod = 21'(nom) * 21'(pct);
		quo = prod / 21'h000064;
		s_d.thr = quo[14:0];
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign thr = s_q.thr;
endmodule
`default_nettype wire

// *** verif/pols_peer_model.sv ***
// peer converters on the group bus and the shared sync line
`timescale 1ns/10ps
`default_nettype none
module pols_peer_model (
	input wire logic clk,
	input wire logic nrst,
	input wire logic ext_sync_en,
	input wire logic [6:0] active_set,
	input wire logic own_fault,
	input wire logic sync_o,
	input wire logic sync_oe_n,
	output logic sync_i,
	output logic [6:0] gbus_active_in,
	output logic gbus_fault_in
);
	logic osc;
	int hold;
	initial begin
		osc = 1'b0;
		forever #30 osc = ~osc;
	end
	// one driver at a time on the sync line, pulled high when idle
	assign sync_i = !sync_oe_n ? sync_o : (ext_sync_en ? osc : 1'b1);
	assign gbus_active_in = active_set;
	// peers fault with us and recover only some cycles after we do
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			hold <= 0;
		end else if (own_fault) begin
			hold <= 60;
		end else if (hold > 0) begin
			hold <= hold - 1;
		end
	end
	assign gbus_fault_in = own_fault || (hold > 0);
endmodule
`default_nettype wire

// *** verif/pols_supervisor_tb.sv ***
// self-checking bench of the point-of-load supervisor
`timescale 1ns/10ps
`default_nettype none
module pols_supervisor_tb;
	localparam logic [7:0] RA [0:12] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04,
		8'h05, 8'h06, 8'h07, 8'h08, 8'h09, 8'h0a, 8'h0e, 8'h3f};
	localparam logic [15:0] RE [0:12] = '{16'h0008, 16'h0ce4, 16'h0073,
		16'h0055, 16'h005a, 16'h0055, 16'h0000, 16'h000a, 16'h000a,
		16'h000a, 16'h0140, 16'h0e2e, 16'h0000};
	localparam logic [15:0] FW [0:3] = '{16'h00c7, 16'h00c8, 16'h0280,
		16'h0281};
	localparam logic [9:0] FE [0:3] = '{10'h140, 10'h0c8, 10'h280, 10'h280};
	localparam logic [2:0] OCM [0:4] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4};
	// expected high side: after 5 cycles, after 3 ms held, after release
	localparam logic [2:0] OCE [0:4] = '{3'h1, 3'h1, 3'h0, 3'h4, 3'h7};
	logic clk, nrst, wr, rd, output_enable, oc_detect, tuning_done;
	logic sw_clk_int, ext_en, sw_clk, high_side_en, low_side_en, pg_o;
	logic pg_oe_n, pg_pin, sync_i, sync_o, sync_oe_n, is_reference;
	logic gbus_active_out, gbus_fault_in, gbus_fault_out;
	logic [7:0] addr;
	logic [15:0] wdata, rdata;
	logic [12:0] setpoint_resistor, vout_mv;
	logic [9:0] freq_khz;
	logic [3:0] phase_pos;
	logic [6:0] active_set, gbus_active_in;
	int n_mismatch = 0;
	int compares = 0;
	pols_supervisor #(.CYC_MS(20)) i_dut (.clk(clk), .nrst(nrst),
		.addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
		.output_enable(output_enable), .setpoint_resistor(setpoint_resistor),
		.vout_mv(vout_mv), .oc_detect(oc_detect), .tuning_done(tuning_done),
		.sw_clk_int(sw_clk_int), .sw_clk(sw_clk),
		.high_side_en(high_side_en), .low_side_en(low_side_en),
		.output_in_regulation_o(pg_o), .output_in_regulation_oe_n(pg_oe_n),
		.sync_i(sync_i), .sync_o(sync_o), .sync_oe_n(sync_oe_n),
		.freq_khz(freq_khz), .phase_pos(phase_pos),
		.is_reference(is_reference), .gbus_active_in(gbus_active_in),
		.gbus_active_out(gbus_active_out), .gbus_fault_in(gbus_fault_in),
		.gbus_fault_out(gbus_fault_out));
	pols_peer_model i_peer (.clk(clk), .nrst(nrst), .ext_sync_en(ext_en),
		.active_set(active_set), .own_fault(gbus_fault_out),
		.sync_o(sync_o), .sync_oe_n(sync_oe_n), .sync_i(sync_i),
		.gbus_active_in(gbus_active_in), .gbus_fault_in(gbus_fault_in));
	// regulation pin has a pull-up on the board
	assign pg_pin = pg_oe_n ? 1'b1 : pg_o;
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	always @(posedge clk) sw_clk_int <= nrst ? ~sw_clk_int : 1'b0;
	task automatic give_verdict;
		$display("mismatches %0d compares %0d", n_mismatch, compares);
		if (n_mismatch == 0 && compares > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	initial begin
		#(30000 * 20);
		n_mismatch++;
		give_verdict();
	end
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic chk16(input string s, input logic [15:0] e,
		input logic [15:0] g);
		compares++;
		if (g !== e) begin
			$display("mismatch %s expected %h seen %h", s, e, g);
			n_mismatch++;
		end
	endtask
	task automatic chk1(input string s, input logic e, input logic g);
		chk16(s, {15'h0000, e}, {15'h0000, g});
	endtask
	task automatic bw(input logic [7:0] a, input logic [15:0] d);
		@(posedge clk);
		wr <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	task automatic br(input logic [7:0] a, output logic [15:0] d);
		@(posedge clk);
		rd <= 1'b1;
		addr <= a;
		@(posedge clk);
		rd <= 1'b0;
		#1 d = rdata;
	endtask
	task automatic rc(input logic [7:0] a, input logic [15:0] e);
		logic [15:0] d;
		br(a, d);
		chk16($sformatf("reg %h", a), e, d);
	endtask
	task automatic rs(input int b, input logic e);
		logic [15:0] d;
		br(8'h0d, d);
		chk1($sformatf("status bit %0d", b), e, d[b]);
	endtask
	initial begin
		logic [15:0] d;
		nrst = 1'b0;
		{wr, rd, output_enable, oc_detect, tuning_done} = 5'h00;
		addr = 8'h00;
		wdata = 16'h0000;
		setpoint_resistor = 13'hce4;
		vout_mv = 13'h0000;
		ext_en = 1'b1;
		active_set = 7'h00;
		repeat (4) @(posedge clk);
		nrst <= 1'b1;
		tick(3);
		for (int i = 0; i < 13; i++) rc(RA[i], RE[i]);
		bw(8'h0e, 16'h0000);
		rc(8'h0e, 16'h0e2e);
		repeat (4) chk1("internal clock", sw_clk_int, sw_clk);
		for (int i = 0; i < 4; i++) begin
			bw(8'h0a, FW[i]);
			tick(2);
			chk16("freq", {6'h00, FE[i]}, {6'h00, freq_khz});
		end
		bw(8'h01, 16'h1000);
		rc(8'h01, 16'h0e2e);
		bw(8'h01, 16'h07d0);
		rc(8'h01, 16'h07d0);
		bw(8'h01, 16'h03dc);
		@(posedge clk) output_enable <= 1'b1;
		tick(3);
		bw(8'h01, 16'h05dc);
		rc(8'h01, 16'h04b0);
		@(posedge clk) output_enable <= 1'b0;
		tick(3);
		bw(8'h01, 16'h03e8);
		@(posedge clk) output_enable <= 1'b1;
		tick(3);
		bw(8'h01, 16'h07d0);
		rc(8'h01, 16'h06a4);
		bw(8'h01, 16'h03e8);
		@(posedge clk) vout_mv <= 13'h384;
		tick(300);
		rs(0, 1'b0);
		@(posedge clk) vout_mv <= 13'h385;
		tick(170);
		rs(0, 1'b0);
		tick(60);
		rs(0, 1'b1);
		chk1("pg pin", 1'b1, pg_pin);
		chk1("pg oe_n", 1'b1, pg_oe_n);
		bw(8'h00, 16'h000c);
		tick(2);
		chk1("pg push-pull", 1'b0, pg_oe_n);
		chk1("pg drive", 1'b1, pg_o);
		@(posedge clk) vout_mv <= 13'h352;
		tick(5);
		rs(0, 1'b1);
		rs(2, 1'b0);
		@(posedge clk) vout_mv <= 13'h351;
		tick(5);
		rs(0, 1'b0);
		rs(2, 1'b1);
		chk1("pg drive", 1'b0, pg_pin);
		bw(8'h00, 16'h0008);
		@(posedge clk) vout_mv <= 13'h3e8;
		tick(250);
		@(posedge clk) vout_mv <= 13'h47e;
		tick(5);
		chk1("low side", 1'b0, low_side_en);
		@(posedge clk) vout_mv <= 13'h47f;
		tick(5);
		chk1("low side", 1'b1, low_side_en);
		chk1("high side", 1'b0, high_side_en);
		rs(1, 1'b1);
		rs(0, 1'b0);
		@(posedge clk) vout_mv <= 13'h3e8;
		tick(5);
		chk1("high side", 1'b1, high_side_en);
		bw(8'h02, 16'h006e);
		@(posedge clk) vout_mv <= 13'h44d;
		tick(5);
		chk1("low side", 1'b1, low_side_en);
		bw(8'h02, 16'h0073);
		bw(8'h01, 16'h044c);
		@(posedge clk) vout_mv <= 13'h47f;
		tick(5);
		chk1("low side", 1'b0, low_side_en);
		bw(8'h01, 16'h03e8);
		@(posedge clk) vout_mv <= 13'h3e8;
		bw(8'h00, 16'h000a);
		tick(10);
		rs(0, 1'b0);
		@(posedge clk) tuning_done <= 1'b1;
		tick(5);
		rs(0, 1'b1);
		@(posedge clk) tuning_done <= 1'b0;
		bw(8'h00, 16'h0018);
		tick(3);
		repeat (4) begin
			#7;
			chk1("sync input", sync_i, sw_clk);
		end
		@(posedge clk) vout_mv <= 13'h47f;
		tick(5);
		chk1("low side", 1'b0, low_side_en);
		chk1("fault out", 1'b1, gbus_fault_out);
		@(posedge clk) vout_mv <= 13'h3e8;
		tick(5);
		br(8'h0d, d);
		chk16("state", 16'h0007, {13'h0000, d[12:10]});
		@(posedge clk) output_enable <= 1'b0;
		@(posedge clk) ext_en <= 1'b0;
		bw(8'h00, 16'h0028);
		tick(2);
		chk1("sync oe_n", 1'b0, sync_oe_n);
		chk1("sync out", sw_clk_int, sync_o);
		bw(8'h00, 16'h0008);
		bw(8'h08, 16'h0002);
		bw(8'h09, 16'h0002);
		for (int i = 0; i < 5; i++) begin
			bw(8'h06, {12'h000, OCM[i], 1'b0});
			@(posedge clk) output_enable <= 1'b1;
			tick(5);
			@(posedge clk) oc_detect <= 1'b1;
			tick(5);
			chk1("oc early", OCE[i][2], high_side_en);
			tick(60);
			chk1("oc held", OCE[i][1], high_side_en);
			@(posedge clk) oc_detect <= 1'b0;
			tick(60);
			chk1("oc gone", OCE[i][0], high_side_en);
			@(posedge clk) output_enable <= 1'b0;
			tick(3);
		end
		bw(8'h06, 16'h0000);
		bw(8'h0b, 16'h000f);
		tick(2);
		chk16("phase cfg", 16'h000f, {12'h000, phase_pos});
		bw(8'h0c, 16'h0002);
		bw(8'h0c, 16'h0007);
		rc(8'h0c, 16'h0002);
		bw(8'h0c, 16'h0006);
		rc(8'h0c, 16'h0006);
		bw(8'h0c, 16'h0002);
		bw(8'h07, 16'h0000);
		@(posedge clk) active_set <= 7'h13;
		@(posedge clk) vout_mv <= 13'h0000;
		bw(8'h00, 16'h0009);
		@(posedge clk) output_enable <= 1'b1;
		tick(5);
		bw(8'h00, 16'h0049);
		tick(5);
		chk1("active out", 1'b1, gbus_active_out);
		chk16("rail phase", 16'h0002, {12'h000, phase_pos});
		chk1("reference", 1'b0, is_reference);
		bw(8'h00, 16'h0009);
		@(posedge clk) vout_mv <= 13'h3e8;
		tick(10);
		@(posedge clk) active_set <= 7'h10;
		tick(5);
		chk1("reference", 1'b1, is_reference);
		chk16("rail phase", 16'h0000, {12'h000, phase_pos});
		bw(8'h00, 16'h0049);
		tick(5);
		chk1("active out", 1'b0, gbus_active_out);
		chk1("high side", 1'b0, high_side_en);
		bw(8'h00, 16'h0009);
		@(posedge clk) oc_detect <= 1'b1;
		tick(5);
		@(posedge clk) oc_detect <= 1'b0;
		tick(20);
		chk1("rail held", 1'b0, high_side_en);
		tick(60);
		chk1("rail restart", 1'b1, high_side_en);
		give_verdict();
	end
endmodule
`default_nettype wire
